// ### rtl/asp_pkg.sv
// Purpose: Shared constants and types of the async serial port
// Assumes: 32-bit APB register slave, 8-bit address
// Notes:   All offsets are byte addresses
package asp_pkg;
  // Register offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_LVL  = 8'h0C;
  localparam logic [7:0] OFF_DIV  = 8'h10;
  localparam logic [7:0] OFF_RIS  = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  // Control fields
  localparam int C_TXEN  = 0;
  localparam int C_RXEN  = 1;
  localparam int C_FEN   = 2;
  localparam int C_WLEN  = 3;
  localparam int C_PEN   = 5;
  localparam int C_EVEN  = 6;
  localparam int C_STICK = 7;
  localparam int C_STP2  = 8;
  localparam int C_BRK   = 9;
  localparam int C_RTSEN = 10;
  localparam int C_CTSEN = 11;
  localparam int C_RXDMA = 12;
  localparam int C_TXDMA = 13;
  localparam int CTRL_W  = 14;
  localparam logic [13:0] CTRL_RST = 14'h001F;
  // Level fields
  localparam int L_TX = 0;
  localparam int L_RX = 3;
  localparam logic [5:0] LVL_RST = 6'h12;
  localparam logic [15:0] DIV_RST = 16'h0004;
  // Interrupt bits
  localparam int I_TXL = 0;
  localparam int I_RXL = 1;
  localparam int I_EOT = 2;
  localparam int I_BRK = 3;
  localparam int I_FE  = 4;
  localparam int I_PE  = 5;
  localparam int N_INT = 6;
  // Status bits
  localparam int S_TXF  = 0;
  localparam int S_TXE  = 1;
  localparam int S_RXF  = 2;
  localparam int S_RXE  = 3;
  localparam int S_BUSY = 4;
  localparam int S_CTS  = 5;
  // Receive word layout
  localparam int W_FE  = 8;
  localparam int W_PE  = 9;
  localparam int W_BRK = 10;
  localparam int RXW   = 11;
  // Bit timing in oversample ticks
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam int MAX_BAUD = 3000000;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKW} asp_rx_t;

  // Threshold in entries for a level code
  function automatic int lvl(input logic [2:0] code, input int depth);
    int k;
    case (code)
      3'd0:    k = 1;
      3'd1:    k = 2;
      3'd2:    k = 4;
      3'd3:    k = 6;
      default: k = 7;
    endcase
    return depth * k / 8;
  endfunction : lvl

  // Parity bit for the enabled data bits
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                   input logic even, input logic stick);
    logic [7:0] m;
    m = 8'hFF >> (2'd3 - wl);
    if (stick) return ~even;
    return even ? ^(d & m) : ~^(d & m);
  endfunction : par_bit
endpackage : asp_pkg

// ### rtl/asp_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to pclk
// Notes:   Idle value set by parameter
`timescale 1ns/10ps
module asp_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= RST;
      q    <= RST;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule : asp_sync

// ### rtl/asp_fifo.sv
// Purpose: Synchronous FIFO with selectable one-entry depth
// Assumes: DEPTH is a power of two
// Notes:   Count output drives levels and requests
`timescale 1ns/10ps
module asp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          one_deep,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  output logic      [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic          push;
  logic          pop;

  assign in_ready  = one_deep ? (count == '0) : (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      count <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule : asp_fifo

// ### rtl/asp_top.sv
// Purpose: Async serial port with FIFOs, APB registers, IRQ and DMA requests
// Assumes: Single clock pclk, 16x oversampled baud tick
// Notes:   Pin inputs pass two flops before use
`timescale 1ns/10ps
module asp_top #(
  parameter int DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             rts_n,
  output logic             irq,
  output logic             tx_dma_sreq,
  output logic             tx_dma_breq,
  output logic             rx_dma_sreq,
  output logic             rx_dma_breq
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [asp_pkg::CTRL_W-1:0] ctrl_r;
  logic [5:0]                 lvl_r;
  logic [15:0]                div_r;
  logic [asp_pkg::N_INT-1:0]  ris_r, mask_r, ris_set;
  logic [15:0]                dcnt_r;
  logic                       tick_r;
  logic                       rxd_s, cts_s;
  logic                       wr_go, rd_go, acc, mapped;
  logic                       tx_iv, tx_ir, tx_ov, tx_pop;
  logic [7:0]                 tx_od;
  logic [CW-1:0]              tx_cnt, rx_cnt, tx_lim, rx_lim;
  logic                       rx_ir, rx_ov, rx_pop;
  logic [asp_pkg::RXW-1:0]    rx_od, rx_w_r;
  logic                       rx_push_r;
  logic                       txl_hit, rxl_hit, txl_d_r, rxl_d_r;
  asp_pkg::asp_tx_t           tx_st;
  asp_pkg::asp_rx_t           rx_st;
  logic [3:0]                 tsub_r, rsub_r;
  logic [2:0]                 tbit_r, rbit_r;
  logic [7:0]                 tsh_r, rsh_r;
  logic                       tpar_r, rpar_r, txd_r, eot_r;
  logic                       brk_r, fe_r, pe_r;
  logic [2:0]                 nlast;
  logic                       fen, pen, cts_ok, is_brk, rx_bad_par;

  assign fen    = ctrl_r[asp_pkg::C_FEN];
  assign pen    = ctrl_r[asp_pkg::C_PEN];
  assign nlast  = 3'd4 + {1'b0, ctrl_r[asp_pkg::C_WLEN +: 2]};
  assign cts_ok = ~ctrl_r[asp_pkg::C_CTSEN] | ~cts_s;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  asp_sync #(.W(2), .RST(2'b11)) u_sync (
    .clk  (pclk),
    .rstn (presetn),
    .d    ({rxd, cts_n}),
    .q    ({rxd_s, cts_s})
  );

  //////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  assign acc    = psel & penable;
  assign wr_go  = acc & pready & pwrite;
  assign rd_go  = acc & pready & ~pwrite;
  assign mapped = (paddr <= asp_pkg::OFF_MASK) && (paddr[1:0] == 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc && !pready && !pwrite) begin
        unique case (paddr)
          asp_pkg::OFF_DATA: prdata <= {21'h0, rx_ov ? rx_od : 11'h000};
          asp_pkg::OFF_STAT: prdata <= {26'h0, ~cts_s, tx_st != asp_pkg::TX_IDLE,
                                        ~rx_ov, ~rx_ir, ~tx_ov, ~tx_ir};
          asp_pkg::OFF_CTRL: prdata <= {18'h0, ctrl_r};
          asp_pkg::OFF_LVL:  prdata <= {26'h0, lvl_r};
          asp_pkg::OFF_DIV:  prdata <= {16'h0, div_r};
          asp_pkg::OFF_RIS:  prdata <= {26'h0, ris_r};
          asp_pkg::OFF_MASK: prdata <= {26'h0, mask_r};
          default:           prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= asp_pkg::CTRL_RST;
      lvl_r  <= asp_pkg::LVL_RST;
      div_r  <= asp_pkg::DIV_RST;
      mask_r <= '0;
    end else if (wr_go) begin
      if (paddr == asp_pkg::OFF_CTRL) ctrl_r <= pwdata[asp_pkg::CTRL_W-1:0];
      if (paddr == asp_pkg::OFF_LVL) lvl_r <= pwdata[5:0];
      if (paddr == asp_pkg::OFF_DIV) div_r <= pwdata[15:0];
      if (paddr == asp_pkg::OFF_MASK) mask_r <= pwdata[asp_pkg::N_INT-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFOs
  // Two independent FIFOs
  assign tx_iv  = wr_go && (paddr == asp_pkg::OFF_DATA);
  assign rx_pop = rd_go && (paddr == asp_pkg::OFF_DATA);

  asp_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
    .clk       (pclk),
    .rstn      (presetn),
    .one_deep  (~fen),
    .in_valid  (tx_iv),
    .in_ready  (tx_ir),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_ov),
    .out_ready (tx_pop),
    .out_data  (tx_od),
    .count     (tx_cnt)
  );

  asp_fifo #(.W(asp_pkg::RXW), .DEPTH(DEPTH)) u_rxf (
    .clk       (pclk),
    .rstn      (presetn),
    .one_deep  (~fen),
    .in_valid  (rx_push_r),
    .in_ready  (rx_ir),
    .in_data   (rx_w_r),
    .out_valid (rx_ov),
    .out_ready (rx_pop),
    .out_data  (rx_od),
    .count     (rx_cnt)
  );

  assign tx_lim  = CW'(asp_pkg::lvl(lvl_r[asp_pkg::L_TX +: 3], DEPTH));
  assign rx_lim  = CW'(asp_pkg::lvl(lvl_r[asp_pkg::L_RX +: 3], DEPTH));
  assign txl_hit = fen ? (tx_cnt <= tx_lim) : (tx_cnt == '0);
  assign rxl_hit = fen ? (rx_cnt >= rx_lim) : (rx_cnt != '0);

  //////////////////////////////////////////////////////////////////////////
  // Baud divider
  // Oversample tick every div cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_r <= '0;
      tick_r <= 1'b0;
    end else if (dcnt_r + 16'd1 >= div_r) begin
      dcnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      dcnt_r <= dcnt_r + 16'd1;
      tick_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  // Hold off while CTS is deasserted
  assign tx_pop = tick_r && tx_st == asp_pkg::TX_IDLE && tx_ov && cts_ok &&
                  ctrl_r[asp_pkg::C_TXEN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st  <= asp_pkg::TX_IDLE;
      tsub_r <= '0;
      tbit_r <= '0;
      tsh_r  <= '0;
      tpar_r <= 1'b0;
      txd_r  <= 1'b1;
      eot_r  <= 1'b0;
    end else begin
      eot_r <= 1'b0;
      if (tick_r) begin
        tsub_r <= tsub_r + 4'd1;
        unique case (tx_st)
          asp_pkg::TX_IDLE: if (tx_pop) begin
            tx_st  <= asp_pkg::TX_START;
            tsub_r <= '0;
            tsh_r  <= tx_od;
            txd_r  <= 1'b0;
            tpar_r <= asp_pkg::par_bit(tx_od, ctrl_r[asp_pkg::C_WLEN +: 2],
                                       ctrl_r[asp_pkg::C_EVEN], ctrl_r[asp_pkg::C_STICK]);
          end
          asp_pkg::TX_START: if (tsub_r == asp_pkg::OVS_LAST) begin
            tx_st  <= asp_pkg::TX_DATA;
            tbit_r <= '0;
            txd_r  <= tsh_r[0];
          end
          asp_pkg::TX_DATA: if (tsub_r == asp_pkg::OVS_LAST) begin
            if (tbit_r == nlast) begin
              tx_st  <= pen ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
              txd_r  <= pen ? tpar_r : 1'b1;
              tbit_r <= '0;
            end else begin
              tsh_r  <= tsh_r >> 1;
              txd_r  <= tsh_r[1];
              tbit_r <= tbit_r + 3'd1;
            end
          end
          asp_pkg::TX_PAR: if (tsub_r == asp_pkg::OVS_LAST) begin
            tx_st <= asp_pkg::TX_STOP;
            txd_r <= 1'b1;
          end
          asp_pkg::TX_STOP: if (tsub_r == asp_pkg::OVS_LAST) begin
            if (ctrl_r[asp_pkg::C_STP2] && tbit_r == 3'd0) begin
              tbit_r <= 3'd1;
            end else begin
              tx_st <= asp_pkg::TX_IDLE;
              eot_r <= ~tx_ov;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) txd <= 1'b1;
    else          txd <= txd_r & ~ctrl_r[asp_pkg::C_BRK];
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver
  assign rx_bad_par = pen && (rpar_r != asp_pkg::par_bit(rsh_r, ctrl_r[asp_pkg::C_WLEN +: 2],
                               ctrl_r[asp_pkg::C_EVEN], ctrl_r[asp_pkg::C_STICK]));
  assign is_brk     = ~rxd_s && rsh_r == 8'h00 && (~pen || ~rpar_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st     <= asp_pkg::RX_IDLE;
      rsub_r    <= '0;
      rbit_r    <= '0;
      rsh_r     <= '0;
      rpar_r    <= 1'b0;
      rx_push_r <= 1'b0;
      rx_w_r    <= '0;
      brk_r     <= 1'b0;
      fe_r      <= 1'b0;
      pe_r      <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      brk_r     <= 1'b0;
      fe_r      <= 1'b0;
      pe_r      <= 1'b0;
      if (tick_r) begin
        rsub_r <= rsub_r + 4'd1;
        unique case (rx_st)
          asp_pkg::RX_IDLE: if (!rxd_s && ctrl_r[asp_pkg::C_RXEN]) begin
            rx_st  <= asp_pkg::RX_START;
            rsub_r <= '0;
            rsh_r  <= '0;
          end
          asp_pkg::RX_START: if (rsub_r == asp_pkg::OVS_MID) begin
            rx_st  <= rxd_s ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
            rsub_r <= '0;
            rbit_r <= '0;
          end
          asp_pkg::RX_DATA: if (rsub_r == asp_pkg::OVS_LAST) begin
            rsh_r[rbit_r] <= rxd_s;
            rbit_r        <= rbit_r + 3'd1;
            if (rbit_r == nlast) rx_st <= pen ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
          end
          asp_pkg::RX_PAR: if (rsub_r == asp_pkg::OVS_LAST) begin
            rpar_r <= rxd_s;
            rx_st  <= asp_pkg::RX_STOP;
          end
          asp_pkg::RX_STOP: if (rsub_r == asp_pkg::OVS_LAST) begin
            // Low through whole frame is break
            rx_st     <= is_brk ? asp_pkg::RX_BRKW : asp_pkg::RX_IDLE;
            rx_push_r <= 1'b1;
            rx_w_r    <= {is_brk, rx_bad_par, ~rxd_s, rsh_r};
            brk_r     <= is_brk;
            fe_r      <= ~rxd_s;
            pe_r      <= rx_bad_par;
          end
          asp_pkg::RX_BRKW: if (rxd_s) rx_st <= asp_pkg::RX_IDLE;
          default: rx_st <= asp_pkg::RX_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupts, flow control, DMA
  // Level crossings, end of transmission, break, framing and parity errors
  assign ris_set = {pe_r, fe_r, brk_r, eot_r, rxl_hit & ~rxl_d_r, txl_hit & ~txl_d_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_r   <= '0;
      txl_d_r <= 1'b1;
      rxl_d_r <= 1'b0;
      irq     <= 1'b0;
    end else begin
      txl_d_r <= txl_hit;
      rxl_d_r <= rxl_hit;
      ris_r   <= (ris_r & ~((wr_go && paddr == asp_pkg::OFF_RIS) ?
                  pwdata[asp_pkg::N_INT-1:0] : '0)) | ris_set;
      irq     <= |(ris_r & mask_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n       <= 1'b1;
      tx_dma_sreq <= 1'b0;
      tx_dma_breq <= 1'b0;
      rx_dma_sreq <= 1'b0;
      rx_dma_breq <= 1'b0;
    end else begin
      rts_n       <= ctrl_r[asp_pkg::C_RTSEN] & ~rx_ir;
      tx_dma_sreq <= ctrl_r[asp_pkg::C_TXDMA] & tx_ir;
      tx_dma_breq <= ctrl_r[asp_pkg::C_TXDMA] & txl_hit;
      rx_dma_sreq <= ctrl_r[asp_pkg::C_RXDMA] & rx_ov;
      rx_dma_breq <= ctrl_r[asp_pkg::C_RXDMA] & rxl_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DIV_SPACING: assert property ((tick_r && div_r >= 16'd2) |=> !tick_r)
    else $error("baud tick too frequent");
  AST_ONE_DEEP: assert property (!fen |-> tx_cnt <= CW'(1))
    else $error("fifo exceeds one entry");
  AST_START_LOW: assert property (tx_st == asp_pkg::TX_START |-> !txd_r)
    else $error("start bit not low");
  AST_STOP_HIGH: assert property (tx_st == asp_pkg::TX_STOP |-> txd_r)
    else $error("stop bit not high");
  AST_CTS_HOLD: assert property ((ctrl_r[asp_pkg::C_CTSEN] && cts_s &&
    tx_st == asp_pkg::TX_IDLE) |=> tx_st == asp_pkg::TX_IDLE)
    else $error("sent while clear to send off");
  AST_BREAK_LOW: assert property (ctrl_r[asp_pkg::C_BRK] |=> !txd)
    else $error("break not driven low");
  AST_RX_SINGLE: assert property ((ctrl_r[asp_pkg::C_RXDMA] && rx_cnt != '0)
    |=> rx_dma_sreq)
    else $error("rx single request missing");
  AST_TX_SINGLE: assert property ((ctrl_r[asp_pkg::C_TXDMA] && tx_ir)
    |=> tx_dma_sreq)
    else $error("tx single request missing");
  AST_EOT: assert property ((tick_r && tx_st == asp_pkg::TX_STOP && !tx_ov &&
    tsub_r == asp_pkg::OVS_LAST && !(ctrl_r[asp_pkg::C_STP2] && tbit_r == 3'd0))
    |=> ##1 ris_r[asp_pkg::I_EOT])
    else $error("end of transmission not flagged");
  AST_RX_START: assert property ((rx_st == asp_pkg::RX_START && tick_r &&
    rsub_r != asp_pkg::OVS_MID) |=> rx_st == asp_pkg::RX_START)
    else $error("start bit not checked at midpoint");

  COV_TX_FRAME: cover property (tx_st == asp_pkg::TX_STOP ##1 tx_st == asp_pkg::TX_IDLE);
  COV_RX_PUSH:  cover property (rx_push_r && !rx_w_r[asp_pkg::W_FE]);
  COV_BREAK:    cover property (brk_r);
  COV_IRQ:      cover property ($rose(irq));
endmodule : asp_top

// ### dv/asp_station.sv
// Purpose: Remote serial station on the far side of the port
// Assumes: One bit lasts BT pclk cycles
// Notes:   Captures txd frames LSB first, sends frames on rxd
`timescale 1ns/10ps
module asp_station #(
  parameter int BT = 16
) (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic rts_n,
  output logic      rxd,
  output logic      cts_n
);
  logic [11:0] got_q[$];
  int          nrx  = 10;
  bit          flow = 1'b0;

  initial begin
    rxd   = 1'b1;
    cts_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // Sample bit centres
  always begin
    logic [11:0] v;
    @(negedge txd);
    v = '0;
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < nrx; i++) begin
      repeat (BT) @(posedge clk);
      v[i] = txd;
    end
    got_q.push_back(v);
  end

  ////////////////////////////////////////////////////////////
  // Framed send, flow honoured
  task automatic send(input logic [11:0] b, input int n);
    while (flow && rts_n) @(posedge clk);
    rxd <= 1'b0;
    repeat (BT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (BT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BT) @(posedge clk);
  endtask : send
endmodule : asp_station

// ### dv/tb.sv
// Purpose: Self-checking bench of the async serial port
// Assumes: DIV set to 1, so one bit is 16 pclk cycles
// Notes:   Station model drives rxd and cts_n
`timescale 1ns/10ps
module tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rxd, cts_n, txd, rts_n, irq;
  logic        tx_dma_sreq, tx_dma_breq, rx_dma_sreq, rx_dma_breq;
  logic [31:0] r, c;
  logic        e;
  logic [11:0] fx;
  int          nb;
  int          err_total = 0;
  int          checked   = 0;
  int          cyc       = 0;
  logic [11:0] rxb[4] = '{12'h15A, 12'h35A, 12'h05A, 12'h000};
  int          rxn[4] = '{9, 10, 9, 11};
  logic [31:0] rxx[4] = '{32'h05A, 32'h25A, 32'h15A, 32'h400};
  logic [31:0] rxm[4] = '{32'h7FF, 32'h7FF, 32'h7FF, 32'h4FF};

  always #50 pclk = ~pclk;

  asp_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .cts_n, .txd, .rts_n, .irq, .tx_dma_sreq, .tx_dma_breq,
    .rx_dma_sreq, .rx_dma_breq);
  asp_station u_stn (.clk(pclk), .txd, .rts_n, .rxd, .cts_n);

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask : rd

  task automatic wt_irq(input logic v);
    for (int n = 0; n < 600 && irq !== v; n++) @(posedge pclk);
  endtask : wt_irq

  task automatic wrap_up;
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(asp_pkg::OFF_CTRL, 32'h1F);
    rd(asp_pkg::OFF_LVL, 32'h12);
    rd(asp_pkg::OFF_DIV, 32'h4);
    rd(asp_pkg::OFF_STAT, 32'h0A);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(asp_pkg::OFF_DIV, 32'h1);
    wr(asp_pkg::OFF_MASK, 32'h3C);
    for (int i = 0; i < 5; i++) begin
      nb = (i < 4 ? i : 3) + 5;
      c = 32'h7;
      c[4:3] = 2'(nb - 5);
      c[5] = i > 0;
      c[6] = i == 2 || i == 3;
      c[7] = i > 2;
      c[8] = i == 2;
      wr(asp_pkg::OFF_CTRL, c);
      fx = 12'(8'h96 + i) & ((12'h1 << nb) - 12'h1);
      if (i > 0) begin
        fx[nb] = (i == 1) ? ~^fx : (i == 2) ? ^fx : (i == 4);
        nb++;
      end
      fx = fx | ((i == 2) ? 12'h3 : 12'h1) << nb;
      u_stn.nrx = nb + 1 + int'(i == 2);
      wr(asp_pkg::OFF_DATA, 32'(8'h96 + i));
      wt_irq(1'b1);
      chk(32'(u_stn.got_q.pop_front()), 32'(fx));
      chk({31'h0, irq}, 32'h1);
      wr(asp_pkg::OFF_RIS, 32'h3F);
    end
    wr(asp_pkg::OFF_CTRL, 32'h41F);
    u_stn.flow = 1'b1;
    chk({31'h0, rts_n}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(asp_pkg::OFF_CTRL, i == 1 ? 32'h47F : 32'h41F);
      u_stn.send(rxb[i], rxn[i]);
      rd(asp_pkg::OFF_DATA, rxx[i], rxm[i]);
    end
    rd(asp_pkg::OFF_RIS, 32'h38, 32'h38);
    chk({31'h0, irq}, 32'h1);
    wr(asp_pkg::OFF_MASK, 32'h0);
    wt_irq(1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(asp_pkg::OFF_RIS, 32'h3F);
    rd(asp_pkg::OFF_RIS, 32'h0, 32'h38);
    u_stn.flow = 1'b0;
    wr(asp_pkg::OFF_LVL, 32'h02);
    wr(asp_pkg::OFF_CTRL, 32'h381F);
    @(posedge pclk);
    chk({28'h0, tx_dma_sreq, tx_dma_breq, rx_dma_sreq, rx_dma_breq}, 32'hC);
    for (int i = 0; i < 17; i++) wr(asp_pkg::OFF_DATA, 32'(i));
    rd(asp_pkg::OFF_STAT, 32'h01, 32'h13);
    chk({30'h0, tx_dma_sreq, tx_dma_breq}, 32'h0);
    u_stn.nrx = 9;
    u_stn.cts_n <= 1'b0;
    for (int n = 0; n < 3000 && u_stn.got_q.size() < 16; n++) @(posedge pclk);
    repeat (400) @(posedge pclk);
    chk(32'(u_stn.got_q.size()), 32'd16);
    chk(32'(u_stn.got_q[15]), 32'h10F);
    u_stn.send(12'h111, 9);
    chk({30'h0, rx_dma_sreq, rx_dma_breq}, 32'h2);
    u_stn.send(12'h122, 9);
    chk({30'h0, rx_dma_sreq, rx_dma_breq}, 32'h3);
    wr(asp_pkg::OFF_LVL, 32'h0A);
    @(posedge pclk);
    chk({30'h0, rx_dma_sreq, rx_dma_breq}, 32'h2);
    u_stn.cts_n <= 1'b1;
    wr(asp_pkg::OFF_CTRL, 32'hC1B);
    wr(asp_pkg::OFF_DATA, 32'h33);
    rd(asp_pkg::OFF_STAT, 32'h01, 32'h01);
    chk({31'h0, rts_n}, 32'h1);
    wr(asp_pkg::OFF_CTRL, 32'hA1B);
    repeat (3) @(posedge pclk);
    chk({31'h0, txd}, 32'h0);
    wrap_up();
  end
endmodule : tb
